//--- hdl/ovw_consts.svh
// Register offsets, field positions and reset values of the overlay window.
`ifndef OVW_CONSTS_SVH
`define OVW_CONSTS_SVH
`define OVW_ADDR_CTRL 8'h10
`define OVW_ADDR_STRIDE 8'h54
`define OVW_ADDR_XB 8'h58
`define OVW_ADDR_YB 8'h5c
`define OVW_ADDR_SIZE 8'h60
`define OVW_EN_BIT 19
`define OVW_ROT_HI 17
`define OVW_ROT_LO 16
`define OVW_BPP_HI 4
`define OVW_BPP_LO 0
`define OVW_END_HI 25
`define OVW_END_LO 16
`define OVW_BEG_HI 9
`define OVW_BEG_LO 0
`define OVW_WID_HI 31
`define OVW_WID_LO 16
`define OVW_HGT_HI 10
`define OVW_HGT_LO 0
`define OVW_RST_WORD 32'h0000_0000
`define OVW_BPP_RST 5'h01
`endif

//--- hdl/ovw_pkg.sv
// Types shared by the overlay window geometry block.
package ovw_pkg;
  typedef enum logic [1:0] {
    OVW_ROT0 = 2'h0,
    OVW_ROT90 = 2'h1,
    OVW_ROT180 = 2'h2,
    OVW_ROT270 = 2'h3
  } ovw_rot_e;
  typedef struct packed {
    logic [9:0] endPos;
    logic [9:0] beginPos;
  } ovw_bounds_s;
  typedef struct packed {
    logic valid;
    logic frameStart;
    logic lineEnd;
    logic [9:0] h;
    logic [9:0] v;
    logic [15:0] mainPixel;
    logic [15:0] ovlPixel;
  } ovw_pix_s;
  typedef struct packed {
    logic overlayEnable;
    ovw_rot_e rotation;
    logic [4:0] bpp;
    logic [9:0] strideWords;
    ovw_bounds_s firstAxis;
    ovw_bounds_s secondAxis;
    logic [19:0] lineWord;
    logic lineHit;
    logic sel;
    logic [15:0] pixOut;
    logic [19:0] fetchWord;
    logic [31:0] prdata;
    logic pslverr;
  } ovw_state_s;
endpackage : ovw_pkg

//--- hdl/ovw_overlay_window_geometry.sv
// Overlay window geometry, stride stepping and pixel selection.
`timescale 1ns/1ps
`include "ovw_consts.svh"
module ovw_overlay_window_geometry (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Scan position and pixels from the display controller.
  input wire ovw_pkg::ovw_pix_s pix,
  // Pixel and fetch results.
  output logic [15:0] pixOut,
  output logic ovlActive,
  output logic [19:0] fetchWord,
  output logic [15:0] ovlWidth,
  output logic [10:0] ovlHeight
);
  ovw_pkg::ovw_state_s s_q;
  ovw_pkg::ovw_state_s s_d;
  logic [2:0] shift;
  logic swapAxes;
  ovw_pkg::ovw_bounds_s hAxis;
  ovw_pkg::ovw_bounds_s vAxis;
  logic [9:0] hWord;
  logic inH;
  logic inV;
  logic hit;
  logic [10:0] hSpan;
  logic [10:0] vSpan;
  logic wrAcc;
  logic setup;
  logic [31:0] rdWord;
  logic mapped;

  // Depth and rotation are the main window's, held here once.
  always_comb begin
    case (s_q.bpp)
      5'h10: shift = 3'h1;
      5'h08: shift = 3'h2;
      5'h04: shift = 3'h3;
      5'h02: shift = 3'h4;
      default: shift = 3'h5;
    endcase
  end

  // At 90 and 270 degrees the first axis runs vertically.
  assign swapAxes = s_q.rotation[0];
  assign hAxis = swapAxes ? s_q.secondAxis : s_q.firstAxis;
  assign vAxis = swapAxes ? s_q.firstAxis : s_q.secondAxis;
  assign hWord = pix.h >> shift;
  assign inH = (hWord >= hAxis.beginPos) && (hWord <= hAxis.endPos);
  assign inV = (pix.v >= vAxis.beginPos) && (pix.v <= vAxis.endPos);
  assign hit = s_q.overlayEnable && pix.valid && inH && inV;

  // Spans are reported in screen terms, so width and height follow the axis swap.
  assign hSpan = {1'b0, hAxis.endPos} - {1'b0, hAxis.beginPos} + 11'h1;
  assign vSpan = {1'b0, vAxis.endPos} - {1'b0, vAxis.beginPos} + 11'h1;
  assign ovlWidth = 16'({5'h0, hSpan} << shift);
  assign ovlHeight = vSpan;

  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    rdWord = `OVW_RST_WORD;
    case (paddr)
      `OVW_ADDR_CTRL: begin
        rdWord[`OVW_EN_BIT] = s_q.overlayEnable;
        rdWord[`OVW_ROT_HI:`OVW_ROT_LO] = s_q.rotation;
        rdWord[`OVW_BPP_HI:`OVW_BPP_LO] = s_q.bpp;
      end
      `OVW_ADDR_STRIDE: rdWord[9:0] = s_q.strideWords;
      `OVW_ADDR_XB: begin
        rdWord[`OVW_END_HI:`OVW_END_LO] = s_q.firstAxis.endPos;
        rdWord[`OVW_BEG_HI:`OVW_BEG_LO] = s_q.firstAxis.beginPos;
      end
      `OVW_ADDR_YB: begin
        rdWord[`OVW_END_HI:`OVW_END_LO] = s_q.secondAxis.endPos;
        rdWord[`OVW_BEG_HI:`OVW_BEG_LO] = s_q.secondAxis.beginPos;
      end
      `OVW_ADDR_SIZE: begin
        rdWord[`OVW_WID_HI:`OVW_WID_LO] = ovlWidth;
        rdWord[`OVW_HGT_HI:`OVW_HGT_LO] = ovlHeight;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    if (setup) begin
      s_d.prdata = pwrite ? `OVW_RST_WORD : rdWord;
      s_d.pslverr = !mapped;
    end
    if (wrAcc) begin
      case (paddr)
        `OVW_ADDR_CTRL: begin
          s_d.overlayEnable = pwdata[`OVW_EN_BIT];
          s_d.rotation =
            ovw_pkg::ovw_rot_e'(pwdata[`OVW_ROT_HI:`OVW_ROT_LO]);
          s_d.bpp = pwdata[`OVW_BPP_HI:`OVW_BPP_LO];
        end
        `OVW_ADDR_STRIDE: s_d.strideWords = pwdata[9:0];
        `OVW_ADDR_XB: begin
          s_d.firstAxis.endPos = pwdata[`OVW_END_HI:`OVW_END_LO];
          s_d.firstAxis.beginPos = pwdata[`OVW_BEG_HI:`OVW_BEG_LO];
        end
        `OVW_ADDR_YB: begin
          s_d.secondAxis.endPos = pwdata[`OVW_END_HI:`OVW_END_LO];
          s_d.secondAxis.beginPos = pwdata[`OVW_BEG_HI:`OVW_BEG_LO];
        end
        default: s_d.pslverr = s_d.pslverr;
      endcase
    end
    // The memory line may be wider than the shown part, so each
    // overlay line advances by the stride, not by the shown width.
    if (hit) begin
      s_d.lineHit = 1'b1;
    end
    if (pix.lineEnd && (s_q.lineHit || hit)) begin
      s_d.lineWord = s_q.lineWord + {10'h0, s_q.strideWords};
      s_d.lineHit = 1'b0;
    end
    if (pix.frameStart) begin
      s_d.lineWord = 20'h0;
      s_d.lineHit = 1'b0;
    end
    s_d.sel = hit;
    s_d.pixOut = hit ? pix.ovlPixel : pix.mainPixel;
    s_d.fetchWord = hit ?
      s_q.lineWord + {10'h0, hWord - hAxis.beginPos} : s_q.fetchWord;
    if (!rst_n) begin
      s_d = '0;
      s_d.bpp = `OVW_BPP_RST;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign pixOut = s_q.pixOut;
  assign ovlActive = s_q.sel;
  assign fetchWord = s_q.fetchWord;

  a_xb_write: assert property (@(posedge clk) disable iff (!rst_n)
    wrAcc && paddr == `OVW_ADDR_XB |=>
      s_q.firstAxis.endPos == $past(pwdata[25:16]) &&
      s_q.firstAxis.beginPos == $past(pwdata[9:0]))
    else $error("X bounds write not stored");

  a_xb_reset: assert property (@(posedge clk)
    !rst_n |=> s_q.firstAxis == '0 && s_q.strideWords == 10'h0)
    else $error("bounds not zero after reset");

  a_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.overlayEnable |=> !ovlActive)
    else $error("overlay shown while disabled");

  a_pix_mux: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 ovlActive |-> pixOut == $past(pix.ovlPixel))
    else $error("overlay pixel not passed");

  a_main_pass: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 !ovlActive |-> pixOut == $past(pix.mainPixel))
    else $error("main pixel not passed");

  a_swap_axes: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.rotation[0] && hit |->
      pix.v >= s_q.firstAxis.beginPos && pix.v <= s_q.firstAxis.endPos)
    else $error("rotated overlay ignores first axis");

  a_stride_step: assert property (@(posedge clk) disable iff (!rst_n)
    pix.lineEnd && s_q.lineHit && !pix.frameStart |=>
      s_q.lineWord == $past(s_q.lineWord) + 20'($past(s_q.strideWords)))
    else $error("line not stepped by stride");

  a_width_calc: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.bpp == 5'h08 && !s_q.rotation[0] |->
      ovlWidth == 16'({5'h0, s_q.firstAxis.endPos - s_q.firstAxis.beginPos
        + 10'h1} << 2))
    else $error("width at 8 bpp wrong");

  a_height_calc: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.rotation[0] && s_q.secondAxis.endPos >= s_q.secondAxis.beginPos
      |-> ovlHeight == 11'(s_q.secondAxis.endPos - s_q.secondAxis.beginPos)
        + 11'h1)
    else $error("height wrong");

  a_bad_addr: assert property (@(posedge clk) disable iff (!rst_n)
    setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");

  c_ovl_show: cover property (@(posedge clk) disable iff (!rst_n)
    !ovlActive ##1 ovlActive ##1 !ovlActive);
  c_rot90: cover property (@(posedge clk) disable iff (!rst_n)
    s_q.rotation == ovw_pkg::OVW_ROT90 && ovlActive);
  c_two_lines: cover property (@(posedge clk) disable iff (!rst_n)
    pix.lineEnd && s_q.lineHit && s_q.lineWord != 20'h0);
endmodule : ovw_overlay_window_geometry

//--- verification/ovw_overlay_window_geometry_tb_top.sv
// Self-checking bench for the overlay window geometry block.
`timescale 1ns/1ps
module ovw_overlay_window_geometry_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ovw_pkg::ovw_pix_s pix = '0;
  logic [15:0] pixOut;
  logic ovlActive;
  logic [19:0] fetchWord;
  logic [15:0] ovlWidth;
  logic [10:0] ovlHeight;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int en, rot, bpp, sh, fb, fe, sb, se, stride, lw, lh;
  logic [31:0] rd;
  logic err;

  ovw_overlay_window_geometry u_dut (.clk(clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix(pix), .pixOut(pixOut), .ovlActive(ovlActive),
    .fetchWord(fetchWord), .ovlWidth(ovlWidth), .ovlHeight(ovlHeight));

  always #20 clk = ~clk;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // The whole run needs about 1170 cycles, so this only cuts a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w, input int d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One pixel slot, then an idle slot, so a pulse is never seen twice.
  task automatic px(input int h, v, fs, le);
    ovw_pkg::ovw_pix_s p;
    int hw, hit, fw;
    p.valid = !(fs || le);
    p.frameStart = fs[0];
    p.lineEnd = le[0];
    p.h = h[9:0];
    p.v = v[9:0];
    p.mainPixel = $urandom;
    p.ovlPixel = $urandom;
    hw = h >> sh;
    hit = en && p.valid && ((rot % 2) ?
      (v >= fb && v <= fe && hw >= sb && hw <= se) :
      (hw >= fb && hw <= fe && v >= sb && v <= se));
    @(posedge clk);
    pix <= p;
    @(posedge clk);
    pix <= '0;
    #1;
    if (p.valid) begin
      chk("active", hit, ovlActive);
      chk("pixel", hit ? p.ovlPixel : p.mainPixel, pixOut);
    end
    if (hit) begin
      fw = (lw + hw - ((rot % 2) ? sb : fb)) & 20'hfffff;
      chk("fetch", fw, fetchWord);
      lh = 1;
    end
    if (fs) begin
      lw = 0;
      lh = 0;
    end
    if (le) begin
      lw = lh ? lw + stride : lw;
      lh = 0;
    end
  endtask : px

  initial begin
    int k, i, j, hw, sw;
    k = $urandom(32'h4222);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(8'h10, 1'b0, 0);
    chk("ctrl", 32'h1, rd);
    chk("pready", 32'h1, pready);
    apb(8'h54, 1'b0, 0);
    chk("stride", 32'h0, rd);
    apb(8'h58, 1'b0, 0);
    chk("xbounds", 32'h0, rd);
    $display("test reset_values done");
    apb(8'h20, 1'b1, -1);
    apb(8'h20, 1'b0, 0);
    chk("unmapped_err", 32'h1, err);
    chk("unmapped_data", 32'h0, rd);
    apb(8'h54, 1'b1, -1);
    apb(8'h54, 1'b0, 0);
    chk("stride_mask", 32'h3ff, rd);
    apb(8'h58, 1'b1, -1);
    apb(8'h58, 1'b0, 0);
    chk("xbounds_mask", 32'h03ff03ff, rd);
    $display("test register_fields done");
    for (k = 0; k < 20; k++) begin
      bpp = 1 << (k % 5);
      sh = 5 - k % 5;
      rot = k / 5;
      en = (k % 4 != 3);
      fb = $urandom % 16;
      fe = fb + $urandom % 16;
      sb = $urandom % 16;
      se = sb + $urandom % 16;
      // Spans are whole words, so widths are multiples of 32/bpp.
      sw = ((rot % 2) ? se - sb : fe - fb) + 1;
      hw = ((rot % 2) ? fe - fb : se - sb) + 1;
      // The memory line is the shown width padded by a few words.
      stride = sw + $urandom % 8;
      apb(8'h54, 1'b1, stride);
      apb(8'h58, 1'b1, (fe << 16) | fb);
      apb(8'h5c, 1'b1, (se << 16) | sb);
      apb(8'h10, 1'b1, (en << 19) | (rot << 16) | bpp);
      #1;
      chk("width", sw << sh, ovlWidth);
      chk("height", hw, ovlHeight);
      apb(8'h60, 1'b0, 0);
      chk("size", ((sw << sh) << 16) | hw, rd);
      px(0, 0, 1, 0);
      for (i = 0; i < 4; i++) begin
        for (j = 0; j < 4; j++) begin
          hw = (rot % 2) ? se : fe;
          hw = (j == 1) ? hw + 1 : (j == 2) ? ((rot % 2) ? sb : fb) : hw;
          hw = (j == 3) ? $urandom % 32 : hw;
          px((hw << sh) | ($urandom & ((1 << sh) - 1)),
            ((rot % 2) ? fb : sb) + i - 1, 0, 0);
        end
        px(0, 0, 0, 1);
      end
      $display("test geometry %0d done", k);
    end
    end_of_test();
  end
endmodule : ovw_overlay_window_geometry_tb_top
